/* rsf_reset_ctrl.sv */
// Purpose: Reset sequencer with sticky reset-cause flags and protected control register.
// Assumes: Oscillator ticks and the brown-out input come from other clock domains.
// Notes:   Status flags are cleared by writing zero; a read of the interrupt status clears it.
`timescale 1ns/1ps

// What this block does
// R1 - A brown-out causes a full reset and sets the brown-out status flag in bit 7.
// R2 - A stack fault, when enabled, causes a partial reset and sets the stack-error flag in bit 2.
// R3 - Bit 7 of the special function register enables the stack-error reset; zero ignores stack faults.
// R4 - Writes to the special function register are blocked unless the write-enable bit 0 of power control is one.
// R5 - After any reset the core starts fetching at program address zero.
// R6 - A full reset holds the core for 1024 fast plus 32 slow oscillator cycles.
// R7 - A partial reset clears only part of the state and releases the core without the power-up delay.
// R8 - A sleep instruction sets the sleep flag in bit 6.
// R9 - A watchdog expiry sets the timeout flag in bit 5 and leaves the other flags alone.
// R10 - An idle instruction sets the standby flag in bit 4.
// R11 - Sleep, timeout, standby and stack-error flags clear on full reset or when software writes zero.
// R12 - The brown-out flag stays set until software writes zero to it.
// R13 - Brown-out detection cannot be disabled by any register or program action.
// R14 - The seven-bit fast oscillator trim centres at code 100000, zero is maximum up and all ones maximum down.
// R15 - A full reset leaves only the brown-out flag set; a partial reset sets only the stack-error flag.
// R16 - The power-up counter counts fast cycles first, then slow cycles, and releases only when both finish.
module rsf_reset_ctrl #(
   parameter int FAST_CYCLES = rsf_pkg::RSF_FAST_CYCLES,
   parameter int SLOW_CYCLES = rsf_pkg::RSF_SLOW_CYCLES
) (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Asynchronous events and oscillator ticks.
   input  wire logic        brownout_in,
   input  wire logic        fast_osc_tick,
   input  wire logic        slow_osc_tick,
   // Core-side events, same clock.
   input  wire logic        stack_fault,
   input  wire logic        sleep_exec,
   input  wire logic        idle_exec,
   input  wire logic        wdt_expire,
   // Core control.
   output logic             core_reset,
   output logic             core_partial_reset,
   output logic      [15:0] fetch_addr,
   output logic      [6:0]  fast_osc_trim,
   output logic             irq
);
   import rsf_pkg::*;

   localparam int FW = $clog2(FAST_CYCLES + 1);
   localparam int SW = $clog2(SLOW_CYCLES + 1);
   localparam int PW = $clog2(RSF_PARTIAL_CYCLES + 1);

   // Three-stage synchronisers; a change counts when stages two and three agree.
   logic [2:0] bo_sync_r;
   logic [2:0] fo_sync_r;
   logic [2:0] so_sync_r;
   logic       fo_level_r;
   logic       so_level_r;
   logic       bo_level_r;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bo_sync_r <= 3'h0;
         fo_sync_r <= 3'h0;
         so_sync_r <= 3'h0;
      end else begin
         bo_sync_r <= {bo_sync_r[1:0], brownout_in};
         fo_sync_r <= {fo_sync_r[1:0], fast_osc_tick};
         so_sync_r <= {so_sync_r[1:0], slow_osc_tick};
      end
   end

   // Filtered levels; a tick counts on a rising filtered edge.
   wire fo_agree = (fo_sync_r[1] == fo_sync_r[2]);
   wire so_agree = (so_sync_r[1] == so_sync_r[2]);
   wire fo_nxt   = fo_agree ? fo_sync_r[2] : fo_level_r;
   wire so_nxt   = so_agree ? so_sync_r[2] : so_level_r;
   wire fast_rise = fo_nxt & ~fo_level_r;
   wire slow_rise = so_nxt & ~so_level_r;
   // Brown-out is a filtered level and has no enable anywhere. (see R13)
   // It only rises or falls once stages two and three agree, so a single late stage cannot end it early.
   wire bo_agree  = (bo_sync_r[1] == bo_sync_r[2]);
   wire brownout  = bo_agree ? bo_sync_r[2] : bo_level_r;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fo_level_r <= 1'b0;
         so_level_r <= 1'b0;
         bo_level_r <= 1'b0;
      end else begin
         fo_level_r <= fo_nxt;
         so_level_r <= so_nxt;
         bo_level_r <= brownout;
      end
   end

   // Register state.
   logic [7:0]          status_r;
   logic                stkrst_en_r;
   logic [RSF_TRIM_W-1:0] trim_r;
   logic                sfwe_r;
   logic [RSF_EV_W-1:0] irq_stat_r;
   logic [RSF_EV_W-1:0] irq_mask_r;
   rsf_state_e          state_r;
   logic [FW-1:0]       fast_cnt_r;
   logic [SW-1:0]       slow_cnt_r;
   logic [PW-1:0]       part_cnt_r;

   // Decode.
   wire wr_status = reg_wr & (reg_addr == RSF_ADDR_STATUS);
   wire wr_sfc    = reg_wr & (reg_addr == RSF_ADDR_SFC) & sfwe_r; // see R4
   wire wr_pwr    = reg_wr & (reg_addr == RSF_ADDR_PWR);
   wire wr_mask   = reg_wr & (reg_addr == RSF_ADDR_IRQMSK);
   wire rd_irqst  = reg_rd & (reg_addr == RSF_ADDR_IRQST);

   wire running   = (state_r == RSF_ST_RUN);
   // A disabled stack-error reset ignores the fault entirely. (see R2) (see R3)
   wire stk_hit   = running & stack_fault & stkrst_en_r;
   wire fast_done = (fast_cnt_r == FW'(FAST_CYCLES - 1)) & fast_rise;
   wire slow_done = (slow_cnt_r == SW'(SLOW_CYCLES - 1)) & slow_rise;
   wire part_done = (part_cnt_r == PW'(RSF_PARTIAL_CYCLES - 1));
   wire ready_ev  = (state_r == RSF_ST_SLOW) & slow_done;

   // Flag clears by writing zero; events win over a clear in the same cycle.
   wire [7:0] wr_keep = wr_status ? reg_wdata : 8'hFF; // see R11 see R12
   wire [7:0] set_vec = ({7'h0, stk_hit}        << RSF_BIT_STKERR)  // see R15
                      | ({7'h0, sleep_exec}     << RSF_BIT_SLEEP)   // see R8
                      | ({7'h0, wdt_expire}     << RSF_BIT_TIMEOUT) // see R9
                      | ({7'h0, idle_exec}      << RSF_BIT_STANDBY); // see R10
   wire [7:0] status_nxt = ((status_r & wr_keep) | set_vec) & RSF_STATUS_MASK;

   // Full reset state: brown-out flag only. (see R1) (see R15)
   localparam logic [7:0] STATUS_FULL = 8'(1 << RSF_BIT_BROWNOUT);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         status_r <= STATUS_FULL;
      end else if (brownout) begin
         status_r <= STATUS_FULL; // see R11
      end else begin
         status_r <= status_nxt;
      end
   end

   // Special function and power control survive a partial reset. (see R7)
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stkrst_en_r <= 1'b0;
         trim_r      <= RSF_TRIM_CENTRE;
         sfwe_r      <= 1'b0;
         irq_mask_r  <= '0;
      end else if (brownout) begin
         stkrst_en_r <= 1'b0;
         trim_r      <= RSF_TRIM_CENTRE;
         sfwe_r      <= 1'b0;
         irq_mask_r  <= '0;
      end else begin
         if (wr_sfc) begin
            stkrst_en_r <= reg_wdata[RSF_BIT_STKRST_EN]; // see R3
            trim_r      <= reg_wdata[RSF_TRIM_W-1:0];    // see R14
         end
         if (wr_pwr) begin
            sfwe_r <= reg_wdata[RSF_BIT_SFWE]; // see R4
         end
         if (wr_mask) begin
            irq_mask_r <= reg_wdata[RSF_EV_W-1:0];
         end
      end
   end

   // Sequencer: fast count, slow count, run; partial reset is a short pulse.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r    <= RSF_ST_FAST;
         fast_cnt_r <= '0;
         slow_cnt_r <= '0;
         part_cnt_r <= '0;
      end else if (brownout) begin
         state_r    <= RSF_ST_FAST; // see R1
         fast_cnt_r <= '0;
         slow_cnt_r <= '0;
         part_cnt_r <= '0;
      end else begin
         case (state_r)
            RSF_ST_FAST: begin
               if (fast_done) begin
                  state_r <= RSF_ST_SLOW; // see R16
               end else if (fast_rise) begin
                  fast_cnt_r <= fast_cnt_r + FW'(1); // see R6
               end
            end
            RSF_ST_SLOW: begin
               if (slow_done) begin
                  state_r <= RSF_ST_RUN; // see R16
               end else if (slow_rise) begin
                  slow_cnt_r <= slow_cnt_r + SW'(1); // see R6
               end
            end
            RSF_ST_RUN: begin
               if (stk_hit) begin
                  state_r    <= RSF_ST_PARTIAL; // see R2
                  part_cnt_r <= '0;
               end
            end
            RSF_ST_PARTIAL: begin
               if (part_done) begin
                  state_r <= RSF_ST_RUN; // see R7
               end else begin
                  part_cnt_r <= part_cnt_r + PW'(1);
               end
            end
            default: state_r <= RSF_ST_FAST;
         endcase
      end
   end

   // Interrupt status: sticky, cleared by a read; a new event wins over the clear.
   wire [RSF_EV_W-1:0] ev_vec = {ready_ev, wdt_expire, stk_hit, brownout};
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (rd_irqst ? '0 : irq_stat_r) | ev_vec;
      end
   end

   // Read mux, data valid the cycle after the strobe.
   logic [7:0] rd_mux;
   assign rd_mux = (reg_addr == RSF_ADDR_STATUS) ? status_r :
                   (reg_addr == RSF_ADDR_SFC)    ? {stkrst_en_r, trim_r} :
                   (reg_addr == RSF_ADDR_PWR)    ? {7'h0, sfwe_r} :
                   (reg_addr == RSF_ADDR_IRQST)  ? {4'h0, irq_stat_r} :
                   (reg_addr == RSF_ADDR_IRQMSK) ? {4'h0, irq_mask_r} : 8'h00;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Core controls held in reset until the sequencer runs.
   assign core_reset         = (state_r == RSF_ST_FAST) | (state_r == RSF_ST_SLOW) | brownout; // see R6
   // A brown-out overrides a partial reset still in progress, so the core never sees both at once.
   assign core_partial_reset = (state_r == RSF_ST_PARTIAL) & ~brownout; // see R7
   assign fetch_addr         = RSF_RESET_VECTOR; // see R5
   assign fast_osc_trim      = trim_r; // see R14
   // A set mask bit blocks its event from the interrupt line.
   assign irq                = |(irq_stat_r & ~irq_mask_r);

endmodule // rsf_reset_ctrl

/* rsf_pkg.sv */
// Purpose: Shared constants for the reset and status flag controller.
// Assumes: 8-bit register port, 10 MHz system clock.
// Notes:   Offsets of the reset status and special function registers are fixed.
package rsf_pkg;

   // Register offsets.
   localparam logic [7:0] RSF_ADDR_STATUS = 8'h2C;
   localparam logic [7:0] RSF_ADDR_SFC    = 8'h43;
   localparam logic [7:0] RSF_ADDR_PWR    = 8'h33;
   localparam logic [7:0] RSF_ADDR_IRQST  = 8'h50;
   localparam logic [7:0] RSF_ADDR_IRQMSK = 8'h51;

   // Status register bit positions.
   localparam int RSF_BIT_BROWNOUT = 7;
   localparam int RSF_BIT_SLEEP    = 6;
   localparam int RSF_BIT_TIMEOUT  = 5;
   localparam int RSF_BIT_STANDBY  = 4;
   localparam int RSF_BIT_STKERR   = 2;
   localparam logic [7:0] RSF_STATUS_MASK = 8'hF4;

   // Special function and power control fields.
   localparam int RSF_BIT_STKRST_EN = 7;
   localparam int RSF_BIT_SFWE      = 0;
   localparam int RSF_TRIM_W        = 7;
   localparam logic [6:0] RSF_TRIM_CENTRE = 7'h20;

   // Interrupt event bits.
   localparam int RSF_EV_BROWNOUT = 0;
   localparam int RSF_EV_STKERR   = 1;
   localparam int RSF_EV_TIMEOUT  = 2;
   localparam int RSF_EV_READY    = 3;
   localparam int RSF_EV_W        = 4;

   // Power-up delay in oscillator cycles.
   localparam int RSF_FAST_CYCLES = 1024;
   localparam int RSF_SLOW_CYCLES = 32;

   // Partial reset pulse length in system clocks.
   localparam int RSF_PARTIAL_CYCLES = 4;

   localparam logic [15:0] RSF_RESET_VECTOR = 16'h0000;

   typedef enum logic [1:0] {
      RSF_ST_FAST,
      RSF_ST_SLOW,
      RSF_ST_RUN,
      RSF_ST_PARTIAL
   } rsf_state_e;

endpackage : rsf_pkg

/* rsf_reset_ctrl_sva.sv */
// Purpose: Port checks for the reset and status flag block.
// Assumes: One mclk domain, rstn active low.
// Notes:   The stack enable is internal, so its gating is checked by the bench.
`timescale 1ns/1ps
module rsf_reset_ctrl_sva
   import rsf_pkg::*;
(
   // Clock and reset.
   input wire logic        mclk,
   input wire logic        rstn,
   // Register port.
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Events.
   input wire logic        brownout_in,
   input wire logic        stack_fault,
   input wire logic        sleep_exec,
   // Core side.
   input wire logic        core_reset,
   input wire logic        core_partial_reset,
   input wire logic [15:0] fetch_addr,
   input wire logic [6:0]  fast_osc_trim,
   input wire logic        irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_vec; fetch_addr == RSF_RESET_VECTOR; endproperty
   a_vec: assert property (p_vec) else $error("fetch address not zero");
   property p_bo; brownout_in [*4] |=> core_reset; endproperty
   a_bo: assert property (p_bo) else $error("brown-out gave no reset");
   property p_pcause; $rose(core_partial_reset) |-> $past(stack_fault) && !$past(core_reset); endproperty
   a_pcause: assert property (p_pcause) else $error("partial reset without fault");
   property p_plen; $rose(core_partial_reset) |-> core_partial_reset [*4] ##1 !core_partial_reset; endproperty
   a_plen: assert property (p_plen) else $error("partial reset length wrong");
   property p_excl; core_reset |-> !core_partial_reset; endproperty
   a_excl: assert property (p_excl) else $error("full and partial reset together");
   property p_trim; $changed(fast_osc_trim) |-> core_reset || $past(reg_wr) && $past(reg_addr) == RSF_ADDR_SFC; endproperty
   a_trim: assert property (p_trim) else $error("trim changed without write");
   property p_sleep; sleep_exec && !brownout_in ##1 reg_rd && reg_addr == RSF_ADDR_STATUS |=> reg_rdata[RSF_BIT_SLEEP]; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flag not set");
   property p_resv; $past(reg_rd) && $past(reg_addr) == RSF_ADDR_STATUS |-> (reg_rdata & ~RSF_STATUS_MASK) == 8'h00; endproperty
   a_resv: assert property (p_resv) else $error("unused status bit set");
   property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("read data not zero outside the read cycle");
   c_part: cover property ($rose(core_partial_reset));
   c_run: cover property ($fell(core_reset));
   c_irq: cover property ($rose(irq));
endmodule // rsf_reset_ctrl_sva
bind rsf_reset_ctrl rsf_reset_ctrl_sva u_sva (.*);

/* rsf_far_side.sv */
// Purpose: Far-side model: both oscillators and the brown-out detector.
// Assumes: Oscillators run slower than mclk so every edge survives the filter.
// Notes:   Brown-out level follows the bench request.
`timescale 1ns/1ps
module rsf_far_side (
   // Clock and request.
   input  wire logic mclk,
   input  wire logic bo_req,
   // Outputs to the block.
   output logic      fast_osc_tick,
   output logic      slow_osc_tick,
   output logic      brownout_in
);
   int fcnt = 0;
   int scnt = 0;
   logic ft_r = 1'b0;
   logic st_r = 1'b0;
   assign fast_osc_tick = ft_r;
   assign slow_osc_tick = st_r;
   // Both run free, so the delay must count fast edges before slow ones.
   always @(posedge mclk) begin
      fcnt <= (fcnt == 2) ? 0 : fcnt + 1;
      scnt <= (scnt == 6) ? 0 : scnt + 1;
      if (fcnt == 2) ft_r <= ~ft_r;
      if (scnt == 6) st_r <= ~st_r;
   end
   assign brownout_in = bo_req;
endmodule // rsf_far_side

/* test_reset_and_status_flags.sv */
// Purpose: Register-level test of the reset and status flag block.
// Assumes: Delay counts shortened to 4 fast and 2 slow cycles.
// Notes:   A set interrupt mask bit is taken to block that interrupt.
`timescale 1ns/1ps
module test_reset_and_status_flags;
   import rsf_pkg::*;
   logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bo_req = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] ev = 4'h0;
   logic fast_t, slow_t, bo, core_reset, part, irq;
   logic [15:0] fetch_addr;
   logic [6:0] trim;
   int failures = 0, n_compared = 0, n;
   always #50 mclk = ~mclk;
   rsf_far_side far (.mclk(mclk), .bo_req(bo_req), .fast_osc_tick(fast_t), .slow_osc_tick(slow_t),
                     .brownout_in(bo));
   rsf_reset_ctrl #(.FAST_CYCLES(4), .SLOW_CYCLES(2)) dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .brownout_in(bo),
      .fast_osc_tick(fast_t), .slow_osc_tick(slow_t), .stack_fault(ev[0]), .sleep_exec(ev[1]),
      .idle_exec(ev[2]), .wdt_expire(ev[3]), .core_reset(core_reset), .core_partial_reset(part),
      .fetch_addr(fetch_addr), .fast_osc_trim(trim), .irq(irq));
   task automatic wrap_up;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Event pulse, then an immediate status read, so the flag is seen at once.
   task automatic fire(input logic [3:0] e, input logic [7:0] exp);
      @(posedge mclk);
      ev <= e;
      @(posedge mclk);
      ev <= 4'h0;
      reg_rd <= 1'b1;
      reg_addr <= RSF_ADDR_STATUS;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata & m}, {8'h00, exp});
   endtask
   task automatic wait_run(output int cnt);
      cnt = 0;
      while (core_reset !== 1'b0 && cnt < 300) begin
         @(posedge mclk);
         cnt++;
      end
      if (cnt >= 300) begin
         failures++;
         wrap_up();
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      wait_run(n);
      chk({15'h0, n > 30}, 16'h0001);
      chk(fetch_addr, RSF_RESET_VECTOR);
      chk({9'h0, trim}, 16'h0020);
      rdc(RSF_ADDR_STATUS, 8'h80);
      rdc(RSF_ADDR_IRQST, 8'h08);
      wr(RSF_ADDR_SFC, 8'h85);
      rdc(RSF_ADDR_SFC, 8'h20);
      wr(RSF_ADDR_PWR, 8'h01);
      wr(RSF_ADDR_SFC, 8'h85);
      rdc(RSF_ADDR_SFC, 8'h85);
      chk({9'h0, trim}, 16'h0005);
      wr(RSF_ADDR_STATUS, 8'h00);
      rdc(RSF_ADDR_STATUS, 8'h00);
      fire(4'h6, 8'h50);
      fire(4'h8, 8'h70);
      wr(RSF_ADDR_STATUS, 8'hDF);
      rdc(RSF_ADDR_STATUS, 8'h50);
      wr(RSF_ADDR_STATUS, 8'h00);
      wr(RSF_ADDR_IRQMSK, 8'hFF);
      fire(4'h1, 8'h04);
      chk({14'h0, part, core_reset}, 16'h0002);
      rdc(RSF_ADDR_SFC, 8'h85);
      chk({15'h0, irq}, 16'h0000);
      wr(RSF_ADDR_IRQMSK, 8'h00);
      @(posedge mclk);
      #1 chk({15'h0, irq}, 16'h0001);
      rdc(RSF_ADDR_IRQST, 8'h06);
      @(posedge mclk);
      #1 chk({15'h0, irq}, 16'h0000);
      wr(RSF_ADDR_SFC, 8'h05);
      wr(RSF_ADDR_STATUS, 8'h00);
      fire(4'h1, 8'h00);
      chk({15'h0, part}, 16'h0000);
      fire(4'h2, 8'h40);
      bo_req <= 1'b1;
      repeat (6) @(posedge mclk);
      #1 chk({15'h0, core_reset}, 16'h0001);
      bo_req <= 1'b0;
      wait_run(n);
      chk({15'h0, n > 30}, 16'h0001);
      #1 chk({15'h0, irq}, 16'h0001);
      rdc(RSF_ADDR_STATUS, 8'h80);
      rdc(RSF_ADDR_IRQST, 8'h09);
      chk({9'h0, trim}, 16'h0020);
      wr(RSF_ADDR_SFC, 8'h85);
      rdc(RSF_ADDR_SFC, 8'h20);
      rdc(8'h00, 8'h00);
      wrap_up();
   end
endmodule // test_reset_and_status_flags
